/* event_log_store.sv */
`timescale 1ns/1ps
module event_log_store import meter_io_pkg::*; (
    input  wire logic                 sys_clk_in,
    input  wire logic                 nrst_in,
    input  wire logic                 log_enable_in,
    input  wire logic                 log_write_in,
    input  wire logic [STAMP_W-1:0]   log_stamp_in,
    input  wire logic [SENSE_MAX-1:0] log_state_in,
    input  wire logic [LOG_IDX_W-1:0] log_read_index_in,
    output logic      [STAMP_W-1:0]   log_stamp_out,
    output logic      [SENSE_MAX-1:0] log_state_out,
    output logic      [LOG_IDX_W-1:0] log_entries_out,
    output logic      [LOG_IDX_W-1:0] log_next_out
);
    logic [STAMP_W-1:0]   stamp_mem [LOG_DEPTH];
    logic [SENSE_MAX-1:0] state_mem [LOG_DEPTH];
    logic                 enable_d;
    logic                 clear;
    logic                 write_ok;

    // changing the enable discards the records
    assign clear    = log_enable_in != enable_d;
    assign write_ok = log_write_in && log_enable_in && !clear;

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            enable_d <= 1'b0;
        end else begin
            enable_d <= log_enable_in;
        end
    end

    // write pointer wraps to the first entry
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            log_next_out    <= '0;
            log_entries_out <= '0;
        end else if (clear) begin
            log_next_out    <= '0;
            log_entries_out <= '0;
        end else if (write_ok) begin
            log_next_out <= (log_next_out == LOG_LAST) ? 5'h00 : log_next_out + 5'h01;
            if (log_entries_out <= LOG_LAST) begin
                log_entries_out <= log_entries_out + 5'h01;
            end
        end
    end

    // entry storage
    always_ff @(posedge sys_clk_in) begin
        if (write_ok) begin
            stamp_mem[log_next_out] <= log_stamp_in;
            state_mem[log_next_out] <= log_state_in;
        end
    end

    // registered read port, out of range reads zero
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            log_stamp_out <= '0;
            log_state_out <= '0;
        end else if (log_read_index_in <= LOG_LAST) begin
            log_stamp_out <= stamp_mem[log_read_index_in];
            log_state_out <= state_mem[log_read_index_in];
        end else begin
            log_stamp_out <= '0;
            log_state_out <= '0;
        end
    end

    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);

    property p_log_wrap;
        write_ok && log_next_out == LOG_LAST |=> log_next_out == 5'h00;
    endproperty
    a_log_wrap: assert property (p_log_wrap) else $error("log pointer did not wrap");

    property p_log_depth;
        log_entries_out <= 5'h14 && log_next_out <= LOG_LAST;
    endproperty
    a_log_depth: assert property (p_log_depth) else $error("log holds more than twenty");

    c_log_wrap: cover property (write_ok && log_next_out == LOG_LAST);
endmodule

/* meter_body_model.sv */
`timescale 1ns/1ps
// body side: time base and energy ticks
module meter_body_model import meter_io_pkg::*; (
    input  wire logic               sys_clk_in,
    input  wire logic               nrst_in,
    input  wire logic [QTY_NUM-1:0] tick_req_in,
    output logic      [STAMP_W-1:0] timestamp_out,
    output logic      [QTY_NUM-1:0] energy_tick_out
);
    // free running time word
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) timestamp_out <= '0;
        else timestamp_out <= timestamp_out + 32'h1;
    end
    // one tick per requested quantity
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) energy_tick_out <= '0;
        else energy_tick_out <= tick_req_in;
    end
endmodule

/* meter_io_channels.sv */
`timescale 1ns/1ps
module meter_io_channels import meter_io_pkg::*; (
    input  wire logic                          sys_clk_in,
    input  wire logic                          nrst_in,
    input  wire logic [1:0]                    module_type_in,
    input  wire logic                          slot_second_in,
    input  wire logic [SENSE_MAX-1:0]          sense_level_in,
    input  wire logic [SENSE_MAX-1:0]          sense_counter_mode_in,
    input  wire logic                          count_clear_in,
    input  wire logic                          event_log_enable_in,
    input  wire logic [STAMP_W-1:0]            timestamp_in,
    input  wire logic [LOG_IDX_W-1:0]          log_read_index_in,
    input  wire logic                          relay_alarm_mode_in,
    input  wire logic                          relay_pulse_sel_in,
    input  wire logic [PULSE_W-1:0]            relay_pulse_cycles_in,
    input  wire logic [RELAYS-1:0]             relay_close_in,
    input  wire logic [RELAYS-1:0]             relay_open_in,
    input  wire logic [RELAYS-1:0]             relay_alarm_in,
    input  wire logic                          switched_energy_mode_in,
    input  wire logic [SWITCHED-1:0]           switched_alarm_in,
    input  wire logic [SWITCHED*QTY_W-1:0]     switched_qty_sel_in,
    input  wire logic [QTY_NUM-1:0]            energy_tick_in,
    input  wire logic [LEVELS*2-1:0]           level_output_range_in,
    input  wire logic [LEVELS*2-1:0]           level_input_range_in,
    output logic      [SENSE_MAX-1:0]          sense_state_out,
    output logic      [SENSE_MAX*COUNT_W-1:0]  sense_count_out,
    output logic      [STAMP_W-1:0]            log_stamp_out,
    output logic      [SENSE_MAX-1:0]          log_state_out,
    output logic      [LOG_IDX_W-1:0]          log_entries_out,
    output logic      [LOG_IDX_W-1:0]          log_next_out,
    output logic      [RELAYS-1:0]             relay_channel_out,
    output logic      [SWITCHED-1:0]           switched_out,
    output logic      [LEVELS-1:0]             level_output_current_out,
    output logic      [LEVELS-1:0]             level_output_live_zero_out,
    output logic      [LEVELS-1:0]             level_input_current_out,
    output logic      [LEVELS-1:0]             level_input_live_zero_out,
    output logic      [4:0]                    sense_first_number_out,
    output logic      [3:0]                    relay_first_number_out,
    output logic      [2:0]                    switched_first_number_out,
    output logic      [2:0]                    level_input_first_number_out
);
    module_type_e         mod_type;
    logic                 slot_second;
    logic                 strap_taken;
    logic [SENSE_MAX-1:0] present;
    logic [SENSE_MAX-1:0] lvl_q;
    logic [SENSE_MAX-1:0] lvl_d;
    logic [SENSE_MAX-1:0] sig_state;
    logic [SENSE_MAX-1:0] sig_state_d;
    logic                 log_write;
    logic                 has_relays;
    logic                 has_switched;

    // type and slot straps caught on first edge after release
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mod_type    <= TYPE_NONE;
            slot_second <= 1'b0;
            strap_taken <= 1'b0;
        end else if (!strap_taken) begin
            mod_type    <= module_type_e'(module_type_in);
            slot_second <= slot_second_in;
            strap_taken <= 1'b1;
        end
    end

    // channel population by type
    always_comb begin
        case (mod_type)
            TYPE_ONE:   present = {SENSE_T1{1'b1}};
            TYPE_TWO,
            TYPE_THREE: present = {{(SENSE_MAX-SENSE_T23){1'b0}}, {SENSE_T23{1'b1}}};
            default:    present = '0;
        endcase
    end
    assign has_relays   = mod_type == TYPE_ONE || mod_type == TYPE_THREE;
    assign has_switched = mod_type == TYPE_TWO;

    // input sampling, idle level is open contact
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            lvl_q <= SENSE_LEVEL_RST;
            lvl_d <= SENSE_LEVEL_RST;
        end else begin
            lvl_q <= sense_level_in;
            lvl_d <= lvl_q;
        end
    end

    // low level means contact closed, reported as one
    assign sig_state = ~lvl_q & present & ~sense_counter_mode_in;

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sense_state_out <= '0;
            sig_state_d     <= '0;
        end else begin
            sense_state_out <= ~lvl_q & present;
            sig_state_d     <= sig_state;
        end
    end

    // pulse counters, one per channel
    genvar gi;
    generate
        for (gi = 0; gi < SENSE_MAX; gi++) begin : g_count
            logic fall;
            assign fall = present[gi] && sense_counter_mode_in[gi] && lvl_d[gi] && !lvl_q[gi];
            always_ff @(posedge sys_clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    sense_count_out[gi*COUNT_W +: COUNT_W] <= '0;
                end else if (fall) begin
                    sense_count_out[gi*COUNT_W +: COUNT_W] <= sense_count_out[gi*COUNT_W +: COUNT_W] + 16'h0001;
                end else if (count_clear_in) begin
                    sense_count_out[gi*COUNT_W +: COUNT_W] <= '0;
                end
            end
        end
    endgenerate

    // log a record on any signal-mode change
    assign log_write = event_log_enable_in && (sig_state != sig_state_d);

    event_log_store u_log (
        .sys_clk_in        (sys_clk_in),
        .nrst_in           (nrst_in),
        .log_enable_in     (event_log_enable_in),
        .log_write_in      (log_write),
        .log_stamp_in      (timestamp_in),
        .log_state_in      (sig_state),
        .log_read_index_in (log_read_index_in),
        .log_stamp_out     (log_stamp_out),
        .log_state_out     (log_state_out),
        .log_entries_out   (log_entries_out),
        .log_next_out      (log_next_out)
    );

    // relay channels, one shared mode for both
    generate
        for (gi = 0; gi < RELAYS; gi++) begin : g_relay
            relay_state_e       rstate;
            logic [PULSE_W-1:0] remain;
            always_ff @(posedge sys_clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    rstate <= RLY_OPEN;
                    remain <= '0;
                end else if (!has_relays) begin
                    rstate <= RLY_OPEN;
                end else if (relay_alarm_mode_in) begin
                    // alarm latches until opened, set wins
                    if (relay_alarm_in[gi]) begin
                        rstate <= RLY_LATCHED;
                    end else if (relay_open_in[gi]) begin
                        rstate <= RLY_OPEN;
                    end else if (rstate == RLY_PULSE) begin
                        rstate <= RLY_OPEN;
                    end
                end else if (relay_close_in[gi]) begin
                    if (relay_pulse_sel_in) begin
                        rstate <= RLY_PULSE;
                        remain <= (relay_pulse_cycles_in == '0) ? 16'h0001 : relay_pulse_cycles_in;
                    end else begin
                        rstate <= RLY_LATCHED;
                    end
                end else if (relay_open_in[gi]) begin
                    rstate <= RLY_OPEN;
                end else begin
                    case (rstate)
                        RLY_PULSE: begin
                            if (remain <= 16'h0001) begin
                                rstate <= RLY_OPEN;
                            end
                            remain <= remain - 16'h0001;
                        end
                        default: ;
                    endcase
                end
            end
            assign relay_channel_out[gi] = rstate != RLY_OPEN;
        end
    endgenerate

    // switched outputs, one shared mode for both
    generate
        for (gi = 0; gi < SWITCHED; gi++) begin : g_switch
            logic [STRETCH_W-1:0] stretch;
            logic [QTY_W-1:0]     qsel;
            assign qsel = switched_qty_sel_in[gi*QTY_W +: QTY_W];
            always_ff @(posedge sys_clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    stretch <= '0;
                end else if (!has_switched || !switched_energy_mode_in) begin
                    stretch <= '0;
                end else if (energy_tick_in[qsel]) begin
                    stretch <= STRETCH_W'(ENERGY_PULSE_CYC);
                end else if (stretch != '0) begin
                    stretch <= stretch - 12'h001;
                end
            end
            always_ff @(posedge sys_clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    switched_out[gi] <= 1'b0;
                end else if (!has_switched) begin
                    switched_out[gi] <= 1'b0;
                end else if (switched_energy_mode_in) begin
                    switched_out[gi] <= energy_tick_in[qsel] || stretch > 12'h001;
                end else begin
                    switched_out[gi] <= switched_alarm_in[gi];
                end
            end
        end
    endgenerate

    // level range selects for the analog front ends
    generate
        for (gi = 0; gi < LEVELS; gi++) begin : g_level
            always_ff @(posedge sys_clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    level_output_current_out[gi]   <= 1'b0;
                    level_output_live_zero_out[gi] <= 1'b0;
                    level_input_current_out[gi]    <= 1'b0;
                    level_input_live_zero_out[gi]  <= 1'b0;
                end else begin
                    level_output_current_out[gi]   <= has_switched && level_output_range_in[gi*2+1];
                    level_output_live_zero_out[gi] <= has_switched && level_output_range_in[gi*2];
                    level_input_current_out[gi]    <= mod_type == TYPE_THREE && level_input_range_in[gi*2+1];
                    level_input_live_zero_out[gi]  <= mod_type == TYPE_THREE && level_input_range_in[gi*2];
                end
            end
        end
    endgenerate

    // global channel numbers of this module
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sense_first_number_out       <= '0;
            relay_first_number_out       <= '0;
            switched_first_number_out    <= '0;
            level_input_first_number_out <= '0;
        end else begin
            sense_first_number_out       <= '0;
            relay_first_number_out       <= '0;
            switched_first_number_out    <= '0;
            level_input_first_number_out <= '0;
            case (mod_type)
                TYPE_ONE: begin
                    sense_first_number_out <= slot_second ? SENSE_BASE_T1_S2 : SENSE_BASE_T1_S1;
                    relay_first_number_out <= slot_second ? RELAY_BASE_T1_S2 : RELAY_BASE_T1_S1;
                end
                TYPE_TWO: begin
                    sense_first_number_out    <= slot_second ? SENSE_BASE_T2_S2 : SENSE_BASE_T2_S1;
                    switched_first_number_out <= slot_second ? PAIR_BASE_S2 : PAIR_BASE_S1;
                end
                TYPE_THREE: begin
                    sense_first_number_out       <= slot_second ? SENSE_BASE_T3_S2 : SENSE_BASE_T3_S1;
                    relay_first_number_out       <= slot_second ? RELAY_BASE_T3_S2 : RELAY_BASE_T3_S1;
                    level_input_first_number_out <= slot_second ? PAIR_BASE_S2 : PAIR_BASE_S1;
                end
                default: ;
            endcase
        end
    end

    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);

    property p_count_step;
        g_count[0].fall |=> sense_count_out[15:0] == $past(sense_count_out[15:0]) + 16'h0001;
    endproperty
    a_count_step: assert property (p_count_step) else $error("counter missed a closure");

    property p_closed_reads_one;
        present[0] && !lvl_q[0] |=> sense_state_out[0];
    endproperty
    a_closed_reads_one: assert property (p_closed_reads_one) else $error("closed contact not reported");

    property p_four_inputs;
        strap_taken && mod_type != TYPE_ONE |-> sense_state_out[5:4] == 2'b00;
    endproperty
    a_four_inputs: assert property (p_four_inputs) else $error("absent input reported");

    property p_alarm_no_pulse;
        relay_alarm_mode_in && has_relays ##1 relay_alarm_mode_in |-> g_relay[0].rstate != RLY_PULSE;
    endproperty
    a_alarm_no_pulse: assert property (p_alarm_no_pulse) else $error("pulse in alarm mode");

    property p_pulse_ends;
        g_relay[0].rstate == RLY_PULSE && g_relay[0].remain == 16'h0001
            && !relay_close_in[0] && !relay_alarm_mode_in && has_relays |=> !relay_channel_out[0];
    endproperty
    a_pulse_ends: assert property (p_pulse_ends) else $error("pulse relay stayed closed");

    property p_latch_holds;
        relay_channel_out[1] && g_relay[1].rstate == RLY_LATCHED && !relay_open_in[1] && has_relays
            |=> relay_channel_out[1];
    endproperty
    a_latch_holds: assert property (p_latch_holds) else $error("latched relay dropped");

    property p_energy_pulse;
        has_switched && switched_energy_mode_in && energy_tick_in[switched_qty_sel_in[1:0]]
            |=> switched_out[0] ##1 switched_out[0];
    endproperty
    a_energy_pulse: assert property (p_energy_pulse) else $error("energy pulse missing");

    property p_alarm_follow;
        has_switched && !switched_energy_mode_in |=> switched_out[1] == $past(switched_alarm_in[1]);
    endproperty
    a_alarm_follow: assert property (p_alarm_follow) else $error("switched alarm wrong");

    property p_out_range;
        has_switched ##1 has_switched |-> level_output_current_out[0] == $past(level_output_range_in[1]);
    endproperty
    a_out_range: assert property (p_out_range) else $error("output range wrong");

    property p_log_on_change;
        event_log_enable_in && u_log.enable_d && sig_state != sig_state_d |=> $changed(log_next_out);
    endproperty
    a_log_on_change: assert property (p_log_on_change) else $error("change not logged");

    c_count: cover property (g_count[0].fall);
    c_pulse: cover property (g_relay[0].rstate == RLY_PULSE ##1 g_relay[0].rstate == RLY_OPEN);
    c_log: cover property (log_write);
    c_energy: cover property (has_switched && switched_out[0]);
endmodule

/* meter_io_pkg.sv */
package meter_io_pkg;

    // channel counts per module type and field widths
    localparam int SENSE_MAX   = 6;
    localparam int SENSE_T1    = 6;
    localparam int SENSE_T23   = 4;
    localparam int RELAYS      = 2;
    localparam int SWITCHED    = 2;
    localparam int LEVELS      = 2;
    localparam int COUNT_W     = 16;
    localparam int STAMP_W     = 32;
    localparam int QTY_NUM     = 4;
    localparam int QTY_W       = 2;
    localparam int PULSE_W     = 16;

    // event log geometry
    localparam int             LOG_DEPTH = 20;
    localparam int             LOG_IDX_W = 5;
    localparam logic [4:0]     LOG_LAST  = 5'h13;

    // timing
    localparam int             CLK_MHZ          = 20;
    localparam int             ENERGY_PULSE_US  = 100;
    localparam int             ENERGY_PULSE_CYC = ENERGY_PULSE_US * CLK_MHZ;
    localparam int             STRETCH_W        = 12;

    // reset values
    localparam logic [5:0]     SENSE_LEVEL_RST  = 6'h3F;

    // global numbering bases per type and slot
    localparam logic [4:0]     SENSE_BASE_T1_S1 = 5'h01;
    localparam logic [4:0]     SENSE_BASE_T2_S1 = 5'h07;
    localparam logic [4:0]     SENSE_BASE_T3_S1 = 5'h0B;
    localparam logic [4:0]     SENSE_BASE_T1_S2 = 5'h0F;
    localparam logic [4:0]     SENSE_BASE_T2_S2 = 5'h15;
    localparam logic [4:0]     SENSE_BASE_T3_S2 = 5'h19;
    localparam logic [3:0]     RELAY_BASE_T1_S1 = 4'h1;
    localparam logic [3:0]     RELAY_BASE_T3_S1 = 4'h3;
    localparam logic [3:0]     RELAY_BASE_T1_S2 = 4'h5;
    localparam logic [3:0]     RELAY_BASE_T3_S2 = 4'h7;
    localparam logic [2:0]     PAIR_BASE_S1     = 3'h1;
    localparam logic [2:0]     PAIR_BASE_S2     = 3'h3;

    typedef enum logic [1:0] {TYPE_NONE, TYPE_ONE, TYPE_TWO, TYPE_THREE} module_type_e;
    // bit 1 selects current, bit 0 selects live zero
    typedef enum logic [1:0] {RANGE_V0_5, RANGE_V1_5, RANGE_I0_20, RANGE_I4_20} level_range_e;
    typedef enum logic [1:0] {RLY_OPEN, RLY_LATCHED, RLY_PULSE} relay_state_e;

endpackage

/* test_meter_io_expansion_channels.sv */
`timescale 1ns/1ps
module test_meter_io_expansion_channels import meter_io_pkg::*;;
    logic        sys_clk_in = 1'b0;
    logic        nrst_in = 1'b0;
    logic        slot_second_in, count_clear_in, event_log_enable_in, relay_alarm_mode_in;
    logic        relay_pulse_sel_in, switched_energy_mode_in;
    logic [1:0]  module_type_in, relay_close_in, relay_open_in, relay_alarm_in, switched_alarm_in;
    logic [1:0]  relay_channel_out, switched_out, level_output_current_out, level_output_live_zero_out;
    logic [1:0]  level_input_current_out, level_input_live_zero_out;
    logic [2:0]  switched_first_number_out, level_input_first_number_out;
    logic [3:0]  switched_qty_sel_in, energy_tick_in, tick_req, level_output_range_in, level_input_range_in;
    logic [3:0]  relay_first_number_out;
    logic [4:0]  log_read_index_in, log_entries_out, log_next_out, sense_first_number_out;
    logic [5:0]  sense_level_in, sense_counter_mode_in, sense_state_out, log_state_out;
    logic [15:0] relay_pulse_cycles_in;
    logic [31:0] timestamp_in, log_stamp_out;
    logic [95:0] sense_count_out;
    int          n_fail = 0;
    int          checks = 0;
    meter_io_channels u_meter_io_channels (.sys_clk_in, .nrst_in, .module_type_in, .slot_second_in,
        .sense_level_in, .sense_counter_mode_in, .count_clear_in, .event_log_enable_in, .timestamp_in,
        .log_read_index_in, .relay_alarm_mode_in, .relay_pulse_sel_in, .relay_pulse_cycles_in, .relay_close_in,
        .relay_open_in, .relay_alarm_in, .switched_energy_mode_in, .switched_alarm_in, .switched_qty_sel_in,
        .energy_tick_in, .level_output_range_in, .level_input_range_in, .sense_state_out, .sense_count_out,
        .log_stamp_out, .log_state_out, .log_entries_out, .log_next_out, .relay_channel_out, .switched_out,
        .level_output_current_out, .level_output_live_zero_out, .level_input_current_out,
        .level_input_live_zero_out, .sense_first_number_out, .relay_first_number_out,
        .switched_first_number_out, .level_input_first_number_out);
    meter_body_model u_meter_body_model (.sys_clk_in, .nrst_in, .tick_req_in(tick_req),
        .timestamp_out(timestamp_in), .energy_tick_out(energy_tick_in));
    // 20 MHz clock
    always #25 sys_clk_in = ~sys_clk_in;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask
    // single module on the body, straps held through reset
    task automatic rst(input logic [1:0] t, input logic s);
        nrst_in = 1'b0;
        module_type_in = t;
        slot_second_in = s;
        cyc(5);
        nrst_in = 1'b1;
        cyc(3);
    endtask
    task automatic t_number;
        logic [4:0] es[6] = '{5'h01, 5'h07, 5'h0B, 5'h0F, 5'h15, 5'h19};
        logic [3:0] er[6] = '{4'h1, 4'h0, 4'h3, 4'h5, 4'h0, 4'h7};
        logic [2:0] ed[6] = '{3'h1, 3'h1, 3'h0, 3'h0, 3'h3, 3'h0};
        logic [2:0] ea[6] = '{3'h0, 3'h0, 3'h1, 3'h0, 3'h0, 3'h3};
        sense_level_in = 6'h00;
        for (int i = 0; i < 6; i++) begin
            rst(2'(i % 3 + 1), i > 2);
            cyc(2);
            chk(sense_first_number_out, es[i], "sense number");
            chk(relay_first_number_out, er[i], "relay number");
            chk(switched_first_number_out, ed[(i % 3 == 1) ? i : 0] & {3{i % 3 == 1}}, "out number");
            chk(level_input_first_number_out, ea[i], "in number");
            chk(sense_state_out, (i % 3 != 0) ? 6'h0F : 6'h3F, "population");
        end
        sense_level_in = 6'h3F;
        $display("numbering end");
    endtask
    task automatic t_sense;
        logic [31:0] s0;
        rst(2'h1, 1'b0);
        sense_counter_mode_in = 6'h02;
        sense_level_in = 6'h3C;
        cyc(3);
        chk(sense_state_out, 6'h03, "closed state");
        sense_level_in = 6'h3F;
        cyc(3);
        chk(sense_count_out[31:0], 32'h0001_0000, "pulse count");
        sense_counter_mode_in = 6'h00;
        event_log_enable_in = 1'b1;
        cyc(4);
        for (int i = 0; i < 21; i++) begin
            sense_level_in[0] = ~sense_level_in[0];
            cyc(4);
        end
        chk(log_entries_out, 5'h14, "log entries");
        chk(log_next_out, 5'h01, "log wrap");
        log_read_index_in = 5'h00;
        cyc(2);
        chk(log_state_out, 6'h01, "log word");
        s0 = log_stamp_out;
        log_read_index_in = 5'h01;
        cyc(2);
        chk(log_state_out, 6'h00, "log second");
        chk(s0 - log_stamp_out, 32'h0000_004C, "log stamp");
        $display("sense end");
    endtask
    task automatic t_relay;
        relay_pulse_cycles_in = 16'h0003;
        relay_pulse_sel_in = 1'b1;
        relay_close_in = 2'b01;
        cyc(1);
        relay_close_in = 2'b00;
        cyc(1);
        chk(relay_channel_out, 2'b01, "pulse start");
        cyc(1);
        chk(relay_channel_out, 2'b01, "pulse hold");
        cyc(1);
        chk(relay_channel_out, 2'b00, "pulse end");
        relay_pulse_sel_in = 1'b0;
        relay_close_in = 2'b11;
        cyc(1);
        relay_close_in = 2'b00;
        cyc(6);
        chk(relay_channel_out, 2'b11, "latch hold");
        relay_open_in = 2'b01;
        cyc(1);
        relay_open_in = 2'b00;
        cyc(1);
        chk(relay_channel_out, 2'b10, "latch open");
        relay_alarm_mode_in = 1'b1;
        relay_pulse_sel_in = 1'b1;
        relay_open_in = 2'b11;
        cyc(1);
        relay_open_in = 2'b00;
        relay_alarm_in = 2'b10;
        cyc(1);
        relay_alarm_in = 2'b00;
        relay_close_in = 2'b01;
        cyc(1);
        relay_close_in = 2'b00;
        cyc(6);
        chk(relay_channel_out, 2'b10, "alarm latch");
        $display("relay end");
    endtask
    task automatic t_switched;
        rst(2'h2, 1'b0);
        switched_energy_mode_in = 1'b1;
        switched_qty_sel_in = 4'h6;
        tick_req = 4'h4;
        cyc(1);
        tick_req = 4'h0;
        cyc(ENERGY_PULSE_CYC);
        chk(switched_out, 2'b01, "energy pulse");
        cyc(1);
        chk(switched_out, 2'b00, "energy end");
        switched_energy_mode_in = 1'b0;
        switched_alarm_in = 2'b10;
        cyc(2);
        chk(switched_out, 2'b10, "alarm output");
        $display("switched end");
    endtask
    task automatic t_range(input logic [1:0] t);
        logic [3:0] p;
        rst(t, 1'b1);
        for (int r = 0; r < 4; r++) begin
            level_output_range_in = {2{2'(r)}};
            level_input_range_in = {2{2'(r)}};
            p = {{2{r[1]}}, {2{r[0]}}};
            cyc(2);
            chk({level_output_current_out, level_output_live_zero_out, level_input_current_out,
                level_input_live_zero_out}, (t == 2'h2) ? {p, 4'h0} : {4'h0, p}, "range");
        end
        $display("range end");
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // main sequence
    initial begin
        {slot_second_in, count_clear_in, event_log_enable_in, relay_alarm_mode_in, relay_pulse_sel_in,
            switched_energy_mode_in, relay_close_in, relay_open_in, relay_alarm_in, switched_alarm_in,
            sense_counter_mode_in, switched_qty_sel_in, tick_req, level_output_range_in,
            level_input_range_in, log_read_index_in, relay_pulse_cycles_in, module_type_in} = '0;
        sense_level_in = 6'h3F;
        t_number;
        t_sense;
        t_relay;
        t_switched;
        t_range(2'h2);
        t_range(2'h3);
        end_of_test;
    end
    // watchdog
    initial begin
        cyc(20000);
        n_fail++;
        end_of_test;
    end
endmodule
